//--- usb_suspend_wake_power_ctrl.sv
// Power management: suspend entry/exit, wake sources, power switch and PM interrupts
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - On USB suspend, optionally enter low power; only wake detection stays active.
// - Host or device resume in low power drives the power switch back on.
// - Always-on general output keeps its value through low-power suspend.
// - Host-assigned address, configuration and U1/U2 enables survive low-power suspend.
// - Adapter mode wakes on host resume, WAKE# or endpoint beacon.
// - pcie_irq_enable bits 1, 2, 27, 30 gate message interrupts to the host.
// - cpu_irq_enable uses the same bits to interrupt the microcontroller.
// - usb_irq_enable uses the same bits to raise a status-in endpoint interrupt.
// - Status bit 1 sets on resume from suspend.
// - Status bit 3 sets on host suspend request; bit 2 on a bit 3 change with bus power high.
// - Status bit 27 on power-state change; bit 30 on endpoint PM interrupt.
// - Without remote wakeup enable, resume requests toward the host are ignored.
// - Control bit 2 lets WAKE# or a beacon wake the device.
// - Bit 7 clear: suspend after status bit 3 written; set: after 3 ms idle.
// - Bit 7 sets at reset in root complex mode without a valid EEPROM.
// - Control bit 11 makes USB line activity a root-port wakeup condition.
// - Writing 1 to usb_status bit 5 starts resume if remote wakeup enabled.
// - usb_status bit 9 reads 1 when the device was previously suspended.
// - PM control bit 0 acks PME_Turn_Off in adapter mode; bit 1 only suspended.
// - Bits 2/3 with pending status-in or IN data give NYET and L1 wakeup.
// - Bits 4/5 allow suspend remote wakeup on pending status-in or IN data.
// - Suspend-request change status rises only while bus power is high.
module usb_suspend_wake_power_ctrl
  import usb_pm_pkg::*;
#(
  parameter int IDLE_COUNT  = IDLE_CYCLES,
  parameter int DELAY_COUNT = DELAY_CYCLES
) (
  // Clock and reset
  input  wire logic              I_CLK,
  input  wire logic              I_RST,
  // Avalon-MM slave
  input  wire logic [11:0]       I_AVS_ADDRESS,
  input  wire logic              I_AVS_READ,
  input  wire logic              I_AVS_WRITE,
  input  wire logic [3:0]        I_AVS_BYTEENABLE,
  input  wire logic [31:0]       I_AVS_WRITEDATA,
  output logic [31:0]            O_AVS_READDATA,
  output logic                   O_AVS_WAITREQUEST,
  // Straps and pins from outside the clock domain
  input  wire logic              I_ADAPTER_MODE,
  input  wire logic              I_ROOT_COMPLEX_MODE,
  input  wire logic              I_EEPROM_VALID,
  input  wire logic              I_USB_BUS_POWER_IN,
  input  wire logic              I_PCIE_WAKE_N,
  // Link-side events (same clock)
  input  wire link_events_type   I_LINK_EVENTS,
  input  wire logic              I_STATUS_IN_PENDING,
  // Link-side requests and power control
  output link_requests_type      O_LINK_REQUESTS,
  output logic                   O_MAIN_POWER_ON,
  output logic                   O_GP_OUTPUT_ZERO,
  output logic                   O_ALWAYS_ON_GP_OUTPUT,
  output logic                   O_LOW_POWER,
  output logic [31:0]            O_RETAINED_PARAMS,
  // Interrupt outputs
  output logic                   O_PCIE_IRQ,
  output logic                   O_CPU_IRQ,
  output logic                   O_STATUS_IN_IRQ
);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_value,
                                              input logic [31:0] new_value,
                                              input logic [3:0]  lanes);
    logic [31:0] result;
    result = old_value;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        result[i*8 +: 8] = new_value[i*8 +: 8];
      end
    end
    return result;
  endfunction : merge_bytes

  logic [31:0]   pcie_irq_enable;
  logic [31:0]   cpu_irq_enable;
  logic [31:0]   usb_irq_enable;
  logic [31:0]   irq_status;
  logic [31:0]   usb_control;
  logic [31:0]   usb_power_mgmt_control;
  logic [1:0]    power_state;
  logic [31:0]   retained_params;
  logic [1:0]    gp_control;
  logic          suspended_before;
  logic          resume_active;
  logic          ack_phase;
  logic          strap_done;
  logic [2:0]    sync_a;
  logic [2:0]    sync_b;
  logic [1:0]    strap_a;
  logic [1:0]    strap_b;
  logic          vbus;
  logic          wake_n;
  logic          adapter;
  pwr_state_type state;
  logic [31:0]   timer;
  logic          susp_req_prev;
  logic [31:0]   next_irq_status;

  // Two-flop synchronisers for pins
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      // Idle pin levels, so release shows no false wake edge
      sync_a <= 3'h2;
      sync_b <= 3'h2;
    end else begin
      sync_a <= {I_ADAPTER_MODE, I_PCIE_WAKE_N, I_USB_BUS_POWER_IN};
      sync_b <= sync_a;
    end
  end
  assign vbus    = sync_b[0];
  assign wake_n  = sync_b[1];
  assign adapter = sync_b[2];

  // Straps pass two flops with no reset: reset must last two edges or more
  always_ff @(posedge I_CLK) begin
    strap_a <= {I_ROOT_COMPLEX_MODE, I_EEPROM_VALID};
    strap_b <= strap_a;
  end

  // Bus access: one wait cycle, answer on the second edge
  logic wr_hit;
  logic rd_hit;
  assign O_AVS_WAITREQUEST = (I_AVS_READ | I_AVS_WRITE) & ~ack_phase;
  assign wr_hit = I_AVS_WRITE & ack_phase;
  assign rd_hit = I_AVS_READ & ~ack_phase;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ack_phase <= 1'b0;
    end else begin
      ack_phase <= (I_AVS_READ | I_AVS_WRITE) & ~ack_phase;
    end
  end

  // Wake sources
  logic host_wake;
  logic pcie_wake;
  logic fifo_wake;
  logic wake_req;
  logic gen_resume_wr;
  assign host_wake = vbus & usb_control[BIT_USB_DETECT_EN] & usb_control[BIT_ROOT_WAKE_EN]
                   & (I_LINK_EVENTS.host_resume | I_LINK_EVENTS.usb_line_active);
  assign pcie_wake = adapter & usb_control[BIT_PCIE_WAKE_EN]
                   & (~wake_n | I_LINK_EVENTS.ep_beacon);
  assign fifo_wake = usb_control[BIT_REMOTE_WAKE_EN]
                   & ((usb_power_mgmt_control[BIT_SUSP_STATUS_IN_ENDPOINT_EN] & I_STATUS_IN_PENDING)
                    | (usb_power_mgmt_control[BIT_SUSP_FIFO_EN] & I_LINK_EVENTS.in_fifo_pending));
  assign gen_resume_wr = wr_hit & (I_AVS_ADDRESS == OFS_USB_STATUS)
                       & I_AVS_BYTEENABLE[0] & I_AVS_WRITEDATA[BIT_GEN_RESUME];
  assign wake_req = host_wake | pcie_wake | fifo_wake;

  // Suspend sequencer
  logic suspend_trigger;
  assign suspend_trigger = usb_control[BIT_IMMED_SUSPEND]
                         ? (timer >= 32'(IDLE_COUNT))
                         : (wr_hit & (I_AVS_ADDRESS == OFS_IRQ_STATUS)
                            & I_AVS_BYTEENABLE[0] & I_AVS_WRITEDATA[BIT_SUSP_REQ]);

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state <= PWR_ACTIVE;
      timer <= ZERO_WORD;
    end else begin
      case (state)
        PWR_ACTIVE: begin
          timer <= (I_LINK_EVENTS.usb_idle) ? timer + 32'h0000_0001 : ZERO_WORD;
          if (I_LINK_EVENTS.usb_suspend && suspend_trigger) begin
            state <= PWR_SUSP_DELAY;
            timer <= ZERO_WORD;
          end
        end
        PWR_SUSP_DELAY: begin
          // Wake requests are not honoured while the delay runs; a usb_status bit 5 write still sends resume
          timer <= timer + 32'h0000_0001;
          if (!I_LINK_EVENTS.usb_suspend) begin
            state <= PWR_ACTIVE;
            timer <= ZERO_WORD;
          end else if (timer >= 32'(DELAY_COUNT)) begin
            state <= PWR_LOW_POWER;
          end
        end
        PWR_LOW_POWER: begin
          timer <= ZERO_WORD;
          if (wake_req) begin
            state <= PWR_RESTORE;
          end
        end
        default: begin
          state <= PWR_ACTIVE;
          timer <= ZERO_WORD;
        end
      endcase
    end
  end

  assign O_LOW_POWER      = (state == PWR_LOW_POWER);
  assign O_MAIN_POWER_ON  = (state != PWR_LOW_POWER);
  assign O_GP_OUTPUT_ZERO = gp_control[0] & O_MAIN_POWER_ON;
  // Not gated by the power state: lives in the always-on domain
  assign O_ALWAYS_ON_GP_OUTPUT = gp_control[1];
  assign O_RETAINED_PARAMS     = retained_params;

  // Remote-wakeup resume toward the host
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      resume_active <= 1'b0;
    end else begin
      resume_active <= (gen_resume_wr | (fifo_wake & state == PWR_LOW_POWER))
                     & usb_control[BIT_REMOTE_WAKE_EN];
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      suspended_before <= 1'b0;
    end else if (state == PWR_LOW_POWER) begin
      suspended_before <= 1'b1;
    end else if (wr_hit && I_AVS_ADDRESS == OFS_USB_STATUS && I_AVS_BYTEENABLE[1]
                 && I_AVS_WRITEDATA[BIT_SUSP_STATUS]) begin
      suspended_before <= 1'b0;
    end
  end

  // Link requests
  logic pme_allowed;
  assign pme_allowed = adapter & usb_power_mgmt_control[BIT_PME_ACK_EN]
                     & (~usb_power_mgmt_control[BIT_PME_ACK_SUSP]
                        | I_LINK_EVENTS.usb_suspend);
  logic l1_hold;
  assign l1_hold = (usb_power_mgmt_control[BIT_L1_STATUS_IN_ENDPOINT_EN] & I_STATUS_IN_PENDING)
                 | (usb_power_mgmt_control[BIT_L1_FIFO_EN] & I_LINK_EVENTS.in_fifo_pending);

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_LINK_REQUESTS <= '0;
    end else begin
      O_LINK_REQUESTS.send_resume    <= resume_active;
      O_LINK_REQUESTS.pme_to_ack     <= I_LINK_EVENTS.pme_turn_off & pme_allowed;
      O_LINK_REQUESTS.l1_nyet        <= I_LINK_EVENTS.l1_request & l1_hold;
      O_LINK_REQUESTS.l1_remote_wake <= l1_hold;
    end
  end

  // Interrupt status: hardware set wins over a write-one clear
  always_comb begin
    next_irq_status = irq_status;
    if (wr_hit && I_AVS_ADDRESS == OFS_IRQ_STATUS) begin
      next_irq_status = irq_status & ~(merge_bytes(ZERO_WORD, I_AVS_WRITEDATA, I_AVS_BYTEENABLE)
                                       & IRQ_EVENT_MASK);
    end
    next_irq_status[BIT_SUSP_REQ] = I_LINK_EVENTS.usb_suspend;
    if (state == PWR_RESTORE) begin
      next_irq_status[BIT_RESUME] = 1'b1;
    end
    if (vbus && (susp_req_prev != I_LINK_EVENTS.usb_suspend)) begin
      next_irq_status[BIT_SUSP_CHANGE] = 1'b1;
    end
    if (I_LINK_EVENTS.ep_pm_irq) begin
      next_irq_status[BIT_EP_PM] = 1'b1;
    end
    if (wr_hit && I_AVS_ADDRESS == OFS_POWER_STATE && I_AVS_BYTEENABLE[0]
        && I_AVS_WRITEDATA[1:0] != power_state) begin
      next_irq_status[BIT_PWR_CHANGE] = 1'b1;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      irq_status    <= ZERO_WORD;
      susp_req_prev <= 1'b0;
    end else begin
      irq_status    <= next_irq_status & IRQ_STATUS_MASK;
      susp_req_prev <= I_LINK_EVENTS.usb_suspend;
    end
  end

  assign O_PCIE_IRQ      = |(irq_status & pcie_irq_enable & IRQ_EVENT_MASK);
  assign O_CPU_IRQ       = |(irq_status & cpu_irq_enable & IRQ_EVENT_MASK);
  assign O_STATUS_IN_IRQ = |(irq_status & usb_irq_enable & IRQ_EVENT_MASK);

  // Register writes; retained parameters never reset by the power sequencer
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pcie_irq_enable        <= ZERO_WORD;
      cpu_irq_enable         <= ZERO_WORD;
      usb_irq_enable         <= ZERO_WORD;
      usb_control            <= USB_CONTROL_RESET;
      usb_power_mgmt_control <= ZERO_WORD;
      power_state            <= 2'h0;
      retained_params        <= ZERO_WORD;
      gp_control             <= 2'h0;
      strap_done             <= 1'b0;
    end else begin
      strap_done <= 1'b1;
      if (!strap_done && strap_b[1] && !strap_b[0]) begin
        usb_control[BIT_IMMED_SUSPEND] <= 1'b1;
      end else if (wr_hit) begin
        if (I_AVS_ADDRESS == OFS_PCIE_IRQ_ENABLE) begin
          pcie_irq_enable <= merge_bytes(pcie_irq_enable, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
        end else if (I_AVS_ADDRESS == OFS_CPU_IRQ_ENABLE) begin
          cpu_irq_enable <= merge_bytes(cpu_irq_enable, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
        end else if (I_AVS_ADDRESS == OFS_USB_IRQ_ENABLE) begin
          usb_irq_enable <= merge_bytes(usb_irq_enable, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
        end else if (I_AVS_ADDRESS == OFS_USB_CONTROL) begin
          usb_control <= (merge_bytes(usb_control, I_AVS_WRITEDATA, I_AVS_BYTEENABLE)
                          & USB_CONTROL_MASK) | USB_CONTROL_RESET;
        end else if (I_AVS_ADDRESS == OFS_PM_CONTROL) begin
          usb_power_mgmt_control <= merge_bytes(usb_power_mgmt_control, I_AVS_WRITEDATA,
                                                I_AVS_BYTEENABLE) & PM_CONTROL_MASK;
        end else if (I_AVS_ADDRESS == OFS_POWER_STATE && I_AVS_BYTEENABLE[0]) begin
          power_state <= I_AVS_WRITEDATA[1:0];
        end else if (I_AVS_ADDRESS == OFS_RETAINED_PARAMS) begin
          retained_params <= merge_bytes(retained_params, I_AVS_WRITEDATA,
                                         I_AVS_BYTEENABLE);
        end else if (I_AVS_ADDRESS == OFS_GP_CONTROL && I_AVS_BYTEENABLE[0]) begin
          gp_control <= I_AVS_WRITEDATA[1:0];
        end
      end
    end
  end

  // Read data, registered; unmapped addresses read zero
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_AVS_READDATA <= ZERO_WORD;
    end else if (rd_hit) begin
      if (I_AVS_ADDRESS == OFS_PCIE_IRQ_ENABLE) begin
        O_AVS_READDATA <= pcie_irq_enable;
      end else if (I_AVS_ADDRESS == OFS_CPU_IRQ_ENABLE) begin
        O_AVS_READDATA <= cpu_irq_enable;
      end else if (I_AVS_ADDRESS == OFS_USB_IRQ_ENABLE) begin
        O_AVS_READDATA <= usb_irq_enable;
      end else if (I_AVS_ADDRESS == OFS_IRQ_STATUS) begin
        O_AVS_READDATA <= irq_status;
      end else if (I_AVS_ADDRESS == OFS_USB_CONTROL) begin
        O_AVS_READDATA <= usb_control;
      end else if (I_AVS_ADDRESS == OFS_USB_STATUS) begin
        O_AVS_READDATA <= {22'h0, suspended_before, 3'h0, resume_active, 5'h0};
      end else if (I_AVS_ADDRESS == OFS_PM_CONTROL) begin
        O_AVS_READDATA <= usb_power_mgmt_control;
      end else if (I_AVS_ADDRESS == OFS_POWER_STATE) begin
        O_AVS_READDATA <= {30'h0, power_state};
      end else if (I_AVS_ADDRESS == OFS_RETAINED_PARAMS) begin
        O_AVS_READDATA <= retained_params;
      end else if (I_AVS_ADDRESS == OFS_GP_CONTROL) begin
        O_AVS_READDATA <= {30'h0, gp_control};
      end else begin
        O_AVS_READDATA <= ZERO_WORD;
      end
    end
  end

endmodule : usb_suspend_wake_power_ctrl

`default_nettype wire

//--- usb_pm_pkg.sv
// Package: register map, field positions, timing constants and carrier types for the power block
package usb_pm_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_PCIE_IRQ_ENABLE  = 12'h014;
  localparam logic [11:0] OFS_CPU_IRQ_ENABLE   = 12'h01C;
  localparam logic [11:0] OFS_USB_IRQ_ENABLE   = 12'h024;
  localparam logic [11:0] OFS_IRQ_STATUS       = 12'h02C;
  localparam logic [11:0] OFS_USB_CONTROL      = 12'h08C;
  localparam logic [11:0] OFS_USB_STATUS       = 12'h090;
  localparam logic [11:0] OFS_PM_CONTROL       = 12'h6C0;
  localparam logic [11:0] OFS_POWER_STATE      = 12'h044;
  localparam logic [11:0] OFS_RETAINED_PARAMS  = 12'h7F0;
  localparam logic [11:0] OFS_GP_CONTROL       = 12'h7F4;

  // Interrupt status / enable bit positions
  localparam int BIT_RESUME       = 1;
  localparam int BIT_SUSP_CHANGE  = 2;
  localparam int BIT_SUSP_REQ     = 3;
  localparam int BIT_PWR_CHANGE   = 27;
  localparam int BIT_EP_PM        = 30;

  // usb_control bits
  localparam int BIT_REMOTE_WAKE_EN  = 1;
  localparam int BIT_PCIE_WAKE_EN    = 2;
  localparam int BIT_USB_DETECT_EN   = 3;
  localparam int BIT_REMOTE_WAKE_SUP = 5;
  localparam int BIT_IMMED_SUSPEND   = 7;
  localparam int BIT_ROOT_WAKE_EN    = 11;

  // usb_status bits
  localparam int BIT_GEN_RESUME   = 5;
  localparam int BIT_SUSP_STATUS  = 9;

  // usb_power_mgmt_control bits
  localparam int BIT_PME_ACK_EN      = 0;
  localparam int BIT_PME_ACK_SUSP    = 1;
  localparam int BIT_L1_STATUS_IN_ENDPOINT_EN    = 2;
  localparam int BIT_L1_FIFO_EN      = 3;
  localparam int BIT_SUSP_STATUS_IN_ENDPOINT_EN  = 4;
  localparam int BIT_SUSP_FIFO_EN    = 5;

  // Writable masks and reset values
  localparam logic [31:0] IRQ_EVENT_MASK    = 32'h4800_0006;
  localparam logic [31:0] IRQ_STATUS_MASK   = 32'h4800_000E;
  localparam logic [31:0] USB_CONTROL_MASK  = 32'h0000_088E;
  localparam logic [31:0] PM_CONTROL_MASK   = 32'h0000_003F;
  localparam logic [31:0] USB_CONTROL_RESET = 32'h0000_0020;
  localparam logic [31:0] ZERO_WORD         = 32'h0000_0000;

  // Timing: idle time before automatic suspend and suspend delay
  localparam int CLK_HZ          = 25_000_000;
  localparam int IDLE_SUSPEND_US = 3000;
  localparam int SUSPEND_DELAY_US = 500;
  localparam int IDLE_CYCLES     = (CLK_HZ / 1_000_000) * IDLE_SUSPEND_US;
  localparam int DELAY_CYCLES    = (CLK_HZ / 1_000_000) * SUSPEND_DELAY_US;

  // Power sequencing states
  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_SUSP_DELAY,
    PWR_LOW_POWER,
    PWR_RESTORE
  } pwr_state_type;

  // Events observed from the link side, carried together
  typedef struct packed {
    logic usb_suspend;
    logic usb_idle;
    logic usb_line_active;
    logic host_resume;
    logic pcie_wake;
    logic ep_beacon;
    logic ep_pm_irq;
    logic pme_turn_off;
    logic l1_request;
    logic in_fifo_pending;
  } link_events_type;

  // Requests toward the link side
  typedef struct packed {
    logic send_resume;
    logic pme_to_ack;
    logic l1_nyet;
    logic l1_remote_wake;
  } link_requests_type;

endpackage : usb_pm_pkg

//--- usb_pm_properties.sv
// Checker: port-level assertions for the power block
`timescale 1ns/1ns
`default_nettype none
module usb_pm_properties
  import usb_pm_pkg::*;
(
  // Clock and reset
  input wire logic              I_CLK,
  input wire logic              I_RST,
  // Bus handshake
  input wire logic              I_AVS_READ,
  input wire logic              I_AVS_WRITE,
  input wire logic              O_AVS_WAITREQUEST,
  // Link and power
  input wire link_events_type   I_LINK_EVENTS,
  input wire logic              I_STATUS_IN_PENDING,
  input wire link_requests_type O_LINK_REQUESTS,
  input wire logic              O_MAIN_POWER_ON,
  input wire logic              O_LOW_POWER,
  input wire logic              O_ALWAYS_ON_GP_OUTPUT,
  input wire logic [31:0]       O_RETAINED_PARAMS
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  AST_POWER_MATCH: assert property (O_MAIN_POWER_ON != O_LOW_POWER)
    else $error("main power and low-power flag disagree");
  AST_LOW_CAUSE: assert property (
    $rose(O_LOW_POWER) |-> $past(I_LINK_EVENTS.usb_suspend))
    else $error("low power entered without bus suspend");
  AST_HOST_RESUME: assert property (
    O_LOW_POWER && I_LINK_EVENTS.host_resume |-> ##[1:8] O_MAIN_POWER_ON)
    else $error("host resume did not restore main power");
  AST_ALWAYS_ON: assert property (
    O_LOW_POWER && $past(O_LOW_POWER) |-> $stable(O_ALWAYS_ON_GP_OUTPUT))
    else $error("always-on output moved in low power");
  AST_RETAIN: assert property (O_LOW_POWER |=> $stable(O_RETAINED_PARAMS))
    else $error("retained parameters lost in low power");
  AST_PME_ACK: assert property (
    O_LINK_REQUESTS.pme_to_ack |-> $past(I_LINK_EVENTS.pme_turn_off))
    else $error("turn-off ack without a turn-off message");
  AST_NYET: assert property (O_LINK_REQUESTS.l1_nyet |->
    $past(I_LINK_EVENTS.l1_request)
    && ($past(I_STATUS_IN_PENDING) || $past(I_LINK_EVENTS.in_fifo_pending)))
    else $error("nyet without a request and pending data");
  AST_WAIT_FIRST: assert property ($rose(I_AVS_READ || I_AVS_WRITE) |-> O_AVS_WAITREQUEST)
    else $error("waitrequest low in first request cycle");
  AST_WAIT_SECOND: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("waitrequest held beyond one cycle");
endmodule : usb_pm_properties

bind usb_suspend_wake_power_ctrl usb_pm_properties usb_pm_properties_i (.*);
`default_nettype wire

//--- usb_pm_host_model.sv
// Partner model: USB and PCI Express hosts as seen from the link side
`timescale 1ns/1ns
`default_nettype none
module usb_pm_host_model
  import usb_pm_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // Scripted host behaviour and device requests
  input  wire link_events_type   i_want,
  input  wire link_requests_type i_req,
  // Events toward the device and answer counts
  output link_events_type        o_ev,
  output logic [7:0]             o_resumes,
  output logic [7:0]             o_acks
);
  logic [1:0] answer;
  // Host drives resume two cycles after it sees a remote-wake request
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ev <= '0;
      answer <= '0;
    end else begin
      answer <= {answer[0], i_req.send_resume};
      o_ev <= link_events_type'(i_want | {3'h0, answer[1], 6'h00});
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_resumes <= '0;
      o_acks <= '0;
    end else begin
      o_resumes <= o_resumes + 8'(i_req.send_resume);
      o_acks <= o_acks + 8'(i_req.pme_to_ack);
    end
  end
endmodule : usb_pm_host_model
`default_nettype wire

//--- tb_top.sv
// Testbench: registers, interrupts, suspend and wake of the power block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import usb_pm_pkg::*;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_type;
  logic clk, rst, rd, wr, wreq, adapt, vbus, wake_n, sip, pwr, gp0, gp1, lowp, rc;
  logic irq_p, irq_c, irq_s;
  logic [11:0] adr;
  logic [31:0] wdat, rdat, ret, q;
  link_events_type want, evs;
  link_requests_type reqs;
  logic [7:0] resumes, acks;
  int failures, checked, cycles;
  row_type rows [8] = '{
    '{OFS_PCIE_IRQ_ENABLE, IRQ_EVENT_MASK, IRQ_EVENT_MASK},
    '{OFS_CPU_IRQ_ENABLE, IRQ_EVENT_MASK, IRQ_EVENT_MASK},
    '{OFS_USB_IRQ_ENABLE, IRQ_EVENT_MASK, IRQ_EVENT_MASK},
    '{OFS_USB_CONTROL, 32'h0000_080C, 32'h0000_082C},
    '{OFS_PM_CONTROL, 32'h0000_003F, 32'h0000_003F},
    '{OFS_GP_CONTROL, 32'h0000_0003, 32'h0000_0003},
    '{OFS_RETAINED_PARAMS, 32'h1234_5678, 32'h1234_5678},
    '{12'h100, 32'hFFFF_FFFF, ZERO_WORD}};

  usb_suspend_wake_power_ctrl #(.IDLE_COUNT(20), .DELAY_COUNT(10)) usb_suspend_wake_power_ctrl_i (
    .I_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
    .I_AVS_BYTEENABLE(4'hF), .I_AVS_WRITEDATA(wdat), .O_AVS_READDATA(rdat),
    .O_AVS_WAITREQUEST(wreq), .I_ADAPTER_MODE(adapt), .I_ROOT_COMPLEX_MODE(rc),
    .I_EEPROM_VALID(!rc), .I_USB_BUS_POWER_IN(vbus), .I_PCIE_WAKE_N(wake_n),
    .I_LINK_EVENTS(evs), .I_STATUS_IN_PENDING(sip), .O_LINK_REQUESTS(reqs),
    .O_MAIN_POWER_ON(pwr), .O_GP_OUTPUT_ZERO(gp0), .O_ALWAYS_ON_GP_OUTPUT(gp1),
    .O_LOW_POWER(lowp), .O_RETAINED_PARAMS(ret), .O_PCIE_IRQ(irq_p), .O_CPU_IRQ(irq_c),
    .O_STATUS_IN_IRQ(irq_s));
  usb_pm_host_model usb_pm_host_model_i (.i_clk(clk), .i_rst(rst), .i_want(want),
    .i_req(reqs), .o_ev(evs), .o_resumes(resumes), .o_acks(acks));

  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Holds the request until waitrequest is seen low; read data lands in q
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic wait_pwr(input logic lvl);
    int n;
    n = 0;
    while (pwr !== lvl && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("main power", 32'(pwr), 32'(lvl));
  endtask : wait_pwr

  task automatic prog();
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, ZERO_WORD);
      chk("register", q, rows[i].e);
    end
  endtask : prog

  task automatic pme(input logic [7:0] exp);
    @(posedge clk);
    want.pme_turn_off <= 1'b1;
    @(posedge clk);
    want.pme_turn_off <= 1'b0;
    repeat (4) @(posedge clk);
    chk("ack count", 32'(acks), 32'(exp));
  endtask : pme

  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  initial begin
    {clk, rd, wr, sip, vbus, rc} = '0;
    {rst, adapt, wake_n} = '1;
    {adr, wdat, want, failures, checked, cycles} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, OFS_USB_CONTROL, ZERO_WORD);
    chk("control reset", q, USB_CONTROL_RESET);
    prog();
    bus(1'b1, OFS_POWER_STATE, 32'h0000_0001);
    bus(1'b0, OFS_IRQ_STATUS, ZERO_WORD);
    chk("status", q, 32'h0800_0000);
    chk("irqs", 32'({irq_p, irq_c, irq_s}), 32'h0000_0007);
    bus(1'b1, OFS_PCIE_IRQ_ENABLE, ZERO_WORD);
    @(negedge clk);
    chk("irqs", 32'({irq_p, irq_c, irq_s}), 32'h0000_0003);
    bus(1'b1, OFS_CPU_IRQ_ENABLE, ZERO_WORD);
    @(negedge clk);
    chk("irqs", 32'({irq_p, irq_c, irq_s}), 32'h0000_0001);
    bus(1'b1, OFS_IRQ_STATUS, 32'h0800_0000);
    @(negedge clk);
    chk("irqs", 32'({irq_p, irq_c, irq_s}), ZERO_WORD);
    @(posedge clk);
    want.ep_pm_irq <= 1'b1;
    @(posedge clk);
    want.ep_pm_irq <= 1'b0;
    repeat (3) @(posedge clk);
    chk("endpoint irq", 32'(irq_s), 32'h0000_0001);
    bus(1'b1, OFS_IRQ_STATUS, 32'h4000_0000);
    bus(1'b1, OFS_USB_STATUS, 32'h0000_0020);
    repeat (4) @(posedge clk);
    chk("resumes", 32'(resumes), ZERO_WORD);
    bus(1'b1, OFS_USB_CONTROL, 32'h0000_080E);
    bus(1'b1, OFS_USB_STATUS, 32'h0000_0020);
    repeat (4) @(posedge clk);
    chk("resumes", 32'(resumes), 32'h0000_0001);
    pme(8'h00);
    // Suspend change is ignored without bus power, then counted with it
    @(posedge clk);
    want.usb_suspend <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, OFS_IRQ_STATUS, ZERO_WORD);
    chk("status", q, 32'h0000_0008);
    want.usb_suspend <= 1'b0;
    vbus <= 1'b1;
    repeat (4) @(posedge clk);
    want.usb_suspend <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, OFS_IRQ_STATUS, ZERO_WORD);
    chk("status", q, 32'h0000_000C);
    bus(1'b1, OFS_IRQ_STATUS, 32'h0000_0004);
    pme(8'h01);
    @(posedge clk);
    {want.l1_request, want.in_fifo_pending, sip} <= 3'h7;
    repeat (3) @(posedge clk);
    chk("nyet", 32'({reqs.l1_nyet, reqs.l1_remote_wake}), 32'h0000_0003);
    {want.l1_request, want.in_fifo_pending, sip} <= 3'h0;
    bus(1'b1, OFS_IRQ_STATUS, 32'h0000_0008);
    wait_pwr(1'b0);
    repeat (20) @(posedge clk);
    chk("low power", 32'(lowp), 32'h0000_0001);
    chk("gp outputs", 32'({gp0, gp1}), 32'h0000_0001);
    chk("retained", ret, 32'h1234_5678);
    @(posedge clk);
    want.host_resume <= 1'b1;
    want.usb_suspend <= 1'b0;
    wait_pwr(1'b1);
    @(posedge clk);
    want.host_resume <= 1'b0;
    bus(1'b0, OFS_IRQ_STATUS, ZERO_WORD);
    chk("resume status", q & 32'h0000_0002, 32'h0000_0002);
    bus(1'b0, OFS_USB_STATUS, ZERO_WORD);
    chk("was suspended", q & 32'h0000_0200, 32'h0000_0200);
    prog();
    // Automatic entry after idle, then wake from the PCI Express wake pin
    bus(1'b1, OFS_USB_CONTROL, 32'h0000_088E);
    @(posedge clk);
    want.usb_suspend <= 1'b1;
    want.usb_idle <= 1'b1;
    wait_pwr(1'b0);
    @(posedge clk);
    wake_n <= 1'b0;
    wait_pwr(1'b1);
    @(posedge clk);
    wake_n <= 1'b1;
    wait_pwr(1'b0);
    @(posedge clk);
    want.usb_line_active <= 1'b1;
    wait_pwr(1'b1);
    @(posedge clk);
    rst <= 1'b1;
    rc <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, OFS_USB_CONTROL, ZERO_WORD);
    chk("control strap", q, 32'h0000_00A0);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
